// >>> rtl/zt_sram_map.svh
// Purpose: Constants for the zero-turnaround synchronous SRAM port
// Assumes: Included by the package and the port module
// Notes:   Widths, lane count and burst encodings only
`ifndef ZT_SRAM_MAP_SVH
`define ZT_SRAM_MAP_SVH
`define ZT_ADDR_W      20
`define ZT_LANES       4
`define ZT_LANE_W      9
`define ZT_BURST_W     2
`define ZT_ORDER_LIN   1'b0
`define ZT_ORDER_ILV   1'b1
`define ZT_STEP_ONE    2'h1
`endif

// >>> rtl/zt_sram_pkg.sv
// Purpose: Types for the zero-turnaround synchronous SRAM port
// Assumes: Map header holds the numbers
// Notes:   Operating mode and command carrier
`include "zt_sram_map.svh"
package zt_sram_pkg;
	typedef enum logic [1:0] {
		MODE_DESEL,
		MODE_READ,
		MODE_WRITE
	} port_mode_t;

	typedef struct packed {
		logic select_low_primary_n;
		logic select_high_secondary;
		logic select_low_tertiary;
		logic load_or_step_strobe;
		logic write_n;
	} cmd_t;
endpackage

// >>> rtl/zero_turnaround_sync_sram_port.sv
// Purpose: Control, burst and lane logic of a no-dead-cycle sync SRAM
// Assumes: Inputs synchronous to clk; array access is external
// Notes:   Bus drive combines registered read state with async enable
`timescale 1ns/1ps
`default_nettype none
`include "zt_sram_map.svh"
module zero_turnaround_sync_sram_port
	import zt_sram_pkg::*;
#(
	parameter int ADDR_W = `ZT_ADDR_W,
	parameter int LANES  = `ZT_LANES,
	parameter int LANE_W = `ZT_LANE_W
) (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      clock_enable_n,
	input  wire cmd_t                      cmd,
	input  wire logic [LANES-1:0]          lane_write_strobes_n,
	input  wire logic [ADDR_W-1:0]         ext_addr,
	input  wire logic                      burst_order_sel,
	input  wire logic                      output_enable_n,
	input  wire logic [LANES*LANE_W-1:0]   dq_in,
	output logic [LANES*LANE_W-1:0]        dq_out,
	output logic [LANES*LANE_W-1:0]        dq_oe,
	output logic [ADDR_W-1:0]              array_addr,
	output logic                           array_read,
	output logic                           array_write,
	output logic [LANES*LANE_W-1:0]        array_wdata,
	output logic [LANES*LANE_W-1:0]        array_bit_mask,
	input  wire logic [LANES*LANE_W-1:0]   array_rdata,
	output port_mode_t                     mode
);
	localparam int DW = LANES * LANE_W;

	initial begin
		if (ADDR_W < `ZT_BURST_W || LANES < 1 || LANE_W < 1)
			$error("Unsupported port geometry");
	end

	typedef struct packed {
		port_mode_t             mode;
		logic [ADDR_W-1:0]      addr;
		logic [ADDR_W-1:0]      start;
		logic [`ZT_BURST_W-1:0] step;
		logic                   wpend;
		logic [LANES-1:0]       wlanes;
		logic [DW-1:0]          rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic                   all_sel;
	logic                   any_lane_write_n;
	logic [`ZT_BURST_W-1:0] nstep;
	logic [`ZT_BURST_W-1:0] nlow;
	logic [DW-1:0]          lane_mask;

	assign all_sel = !cmd.select_low_primary_n && cmd.select_high_secondary
		&& !cmd.select_low_tertiary;
	assign any_lane_write_n = &lane_write_strobes_n;
	assign nstep = s_q.step + `ZT_STEP_ONE;

	always_comb begin
		if (burst_order_sel == `ZT_ORDER_ILV)
			nlow = s_q.start[`ZT_BURST_W-1:0] ^ nstep;
		else
			nlow = s_q.start[`ZT_BURST_W-1:0] + nstep;
	end

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_mask[g*LANE_W +: LANE_W] =
				{LANE_W{!s_q.wlanes[g]}};
			property p_lane;
				@(posedge clk) disable iff (!rstn)
				!clock_enable_n && !cmd.load_or_step_strobe && all_sel
					&& !cmd.write_n
				|=> array_bit_mask[g*LANE_W +: LANE_W]
					== {LANE_W{!$past(lane_write_strobes_n[g])}};
			endproperty
			a_lane: assert property (p_lane)
				else $error("Lane mask wrong");
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.wpend = 1'b0;
		if (!clock_enable_n) begin
			s_d.rdata = array_rdata;
			if (!cmd.load_or_step_strobe) begin
				s_d.step  = '0;
				s_d.start = ext_addr;
				s_d.addr  = ext_addr;
				if (!all_sel) begin
					s_d.mode = MODE_DESEL;
				end else if (cmd.write_n) begin
					s_d.mode = MODE_READ;
				end else begin
					s_d.mode   = MODE_WRITE;
					s_d.wpend  = !any_lane_write_n;
					s_d.wlanes = lane_write_strobes_n;
				end
			end else begin
				s_d.step = nstep;
				s_d.addr = {s_q.start[ADDR_W-1:`ZT_BURST_W], nlow};
				if (s_q.mode == MODE_WRITE) begin
					s_d.wpend  = !any_lane_write_n;
					s_d.wlanes = lane_write_strobes_n;
				end
			end
		end else begin
			s_d.wpend = s_q.wpend;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Data phase one edge after the address, which is why stall holds wpend
	assign array_addr     = s_q.addr;
	assign array_read     = (s_q.mode == MODE_READ);
	assign array_write    = s_q.wpend && !clock_enable_n;
	assign array_wdata    = dq_in;
	assign array_bit_mask = lane_mask;
	assign mode           = s_q.mode;
	assign dq_out         = s_q.rdata;
	assign dq_oe = {DW{(s_q.mode == MODE_READ) && !output_enable_n}};

	property p_ignore_holds;
		@(posedge clk) disable iff (!rstn)
		clock_enable_n |=> $stable(s_q.addr) && $stable(s_q.mode);
	endproperty
	a_ignore_holds: assert property (p_ignore_holds)
		else $error("State moved on ignored edge");

	property p_desel;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && !cmd.load_or_step_strobe && !all_sel
		|=> mode == MODE_DESEL && dq_oe == '0;
	endproperty
	a_desel: assert property (p_desel)
		else $error("Deselect not taken");

	property p_read_start;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && !cmd.load_or_step_strobe && all_sel && cmd.write_n
		|=> mode == MODE_READ && array_addr == $past(ext_addr);
	endproperty
	a_read_start: assert property (p_read_start)
		else $error("Read start wrong");

	property p_write_start;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && !cmd.load_or_step_strobe && all_sel && !cmd.write_n
		|=> mode == MODE_WRITE && s_q.wpend == !$past(any_lane_write_n);
	endproperty
	a_write_start: assert property (p_write_start)
		else $error("Write start wrong");

	property p_abort;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && any_lane_write_n |=> !s_q.wpend;
	endproperty
	a_abort: assert property (p_abort)
		else $error("Aborted write still pending");

	property p_stall_no_write;
		@(posedge clk) disable iff (!rstn)
		clock_enable_n |-> !array_write;
	endproperty
	a_stall_no_write: assert property (p_stall_no_write)
		else $error("Array written on ignored edge");

	property p_step_linear;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && cmd.load_or_step_strobe && !burst_order_sel
		|=> array_addr[1:0] == $past(array_addr[1:0]) + 2'h1
			&& array_addr[ADDR_W-1:2] == $past(array_addr[ADDR_W-1:2]);
	endproperty
	a_step_linear: assert property (p_step_linear)
		else $error("Linear step wrong");

	sequence s_ilv_load;
		!clock_enable_n && !cmd.load_or_step_strobe && burst_order_sel;
	endsequence
	sequence s_ilv_step;
		!clock_enable_n && cmd.load_or_step_strobe && burst_order_sel;
	endsequence
	property p_step_ilv;
		@(posedge clk) disable iff (!rstn)
		s_ilv_load ##1 s_ilv_step |=> array_addr[1:0] ==
			($past(array_addr[1:0]) ^ 2'h1);
	endproperty
	a_step_ilv: assert property (p_step_ilv)
		else $error("Interleaved first step wrong");

	property p_oe;
		@(posedge clk) disable iff (!rstn)
		dq_oe != '0 |-> mode == MODE_READ && !output_enable_n;
	endproperty
	a_oe: assert property (p_oe)
		else $error("Bus driven outside read");

	property p_step_ilv_second;
		@(posedge clk) disable iff (!rstn)
		s_ilv_load ##1 s_ilv_step ##1 s_ilv_step |=> array_addr[1:0] ==
			($past(array_addr[1:0], 2) ^ 2'h2);
	endproperty
	a_step_ilv_second: assert property (p_step_ilv_second)
		else $error("Interleaved second step wrong");

	property p_step_upper;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && cmd.load_or_step_strobe
		|=> array_addr[ADDR_W-1:2] == $past(array_addr[ADDR_W-1:2]);
	endproperty
	a_step_upper: assert property (p_step_upper)
		else $error("Upper address moved on step");

	property p_read_cont;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && cmd.load_or_step_strobe && mode == MODE_READ
		|=> mode == MODE_READ;
	endproperty
	a_read_cont: assert property (p_read_cont)
		else $error("Read burst not continued");

	property p_read_capture;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n |=> dq_out == $past(array_rdata);
	endproperty
	a_read_capture: assert property (p_read_capture)
		else $error("Read data not captured");

	property p_write_cont;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && cmd.load_or_step_strobe && mode == MODE_WRITE
			&& !any_lane_write_n
		|=> s_q.wpend && s_q.wlanes == $past(lane_write_strobes_n);
	endproperty
	a_write_cont: assert property (p_write_cont)
		else $error("Write burst step lost");

	property p_abort_no_write;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && any_lane_write_n
			&& ((!cmd.load_or_step_strobe && all_sel && !cmd.write_n)
			|| (cmd.load_or_step_strobe && mode == MODE_WRITE))
		|=> !array_write;
	endproperty
	a_abort_no_write: assert property (p_abort_no_write)
		else $error("Aborted write reached array");

	property p_desel_stays;
		@(posedge clk) disable iff (!rstn)
		!clock_enable_n && cmd.load_or_step_strobe && mode == MODE_DESEL
		|=> mode == MODE_DESEL && dq_oe == '0;
	endproperty
	a_desel_stays: assert property (p_desel_stays)
		else $error("Deselect left on step");

	property p_stall_wpend;
		@(posedge clk) disable iff (!rstn)
		clock_enable_n |=> s_q.wpend == $past(s_q.wpend);
	endproperty
	a_stall_wpend: assert property (p_stall_wpend)
		else $error("Pending write lost on stall");

	property p_stall_rdata;
		@(posedge clk) disable iff (!rstn)
		clock_enable_n |=> $stable(dq_out);
	endproperty
	a_stall_rdata: assert property (p_stall_rdata)
		else $error("Read data moved on stall");

	property p_read_drive;
		@(posedge clk) disable iff (!rstn)
		mode == MODE_READ && !output_enable_n |-> dq_oe == '1;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("Read not driven");

	property p_reset;
		@(posedge clk)
		!rstn |=> mode == MODE_DESEL && array_addr == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("Reset state wrong");
endmodule
`default_nettype wire

// >>> tb/sram_array_model.sv
// Purpose: Storage array seen behind the SRAM port
// Assumes: Combinational read, write at clock edge
// Notes:   Idle read shows inverted data
`timescale 1ns/1ps
`default_nettype none
module sram_array_model (
	input  wire logic        clk,
	input  wire logic [19:0] array_addr,
	input  wire logic        array_read,
	input  wire logic        array_write,
	input  wire logic [35:0] array_wdata,
	input  wire logic [35:0] array_bit_mask,
	output logic      [35:0] array_rdata
);
	logic [35:0] mem [logic [19:0]];
	logic [35:0] rd;
	int          n = 0;
	always @(array_addr or array_read or n) begin
		rd = mem.exists(array_addr) ? mem[array_addr] : 36'h0;
		array_rdata = array_read ? rd : ~rd;
	end
	always @(posedge clk) begin
		if (array_write) begin
			mem[array_addr] = rd ^ ((rd ^ array_wdata) & array_bit_mask);
			n = n + 1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the sync SRAM port
// Assumes: Array model answers at once
// Notes:   Bursts written then read in both orders
`timescale 1ns/1ps
`default_nettype none
module tb;
	import zt_sram_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, ce_n = 1'b0, oe_n = 1'b0;
	logic        order = 1'b0, wp = 1'b0, off, ar, aw;
	cmd_t        cmd = 5'h19;
	logic [3:0]  sn = 4'hF, ps;
	logic [19:0] addr = 20'h0, st, ca, pa, aa;
	logic [35:0] wd = 36'h0, dq, oe, awd, am, ard, m;
	logic [7:0]  lf = 8'h1D;
	logic [1:0]  k, md = 2'h0;
	port_mode_t  mode;
	logic [35:0] em [logic [19:0]];
	logic [35:0] eq [$];
	int          bad_count = 0, comparisons = 0;
	zero_turnaround_sync_sram_port i_zero_turnaround_sync_sram_port (
		.clk(clk), .rstn(rstn), .clock_enable_n(ce_n), .cmd(cmd),
		.lane_write_strobes_n(sn), .ext_addr(addr), .burst_order_sel(order),
		.output_enable_n(oe_n), .dq_in(wd), .dq_out(dq), .dq_oe(oe),
		.array_addr(aa), .array_read(ar), .array_write(aw),
		.array_wdata(awd), .array_bit_mask(am), .array_rdata(ard),
		.mode(mode));
	sram_array_model i_sram_array_model (.clk(clk), .array_addr(aa),
		.array_read(ar), .array_write(aw), .array_wdata(awd),
		.array_bit_mask(am), .array_rdata(ard));
	always #2 clk = ~clk;
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk_data(input logic [35:0] g, input logic [35:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_oe(input logic [35:0] g, input logic [35:0] e);
		chk_data(g, e);
	endtask
	task automatic cyc(input cmd_t c, input logic [3:0] s, input bit h);
		@(negedge clk);
		chk_oe(oe, {36{md == 2'h1 && !oe_n}});
		lf = nx(lf);
		oe_n = lf[0];
		cmd = c;
		sn = s;
		ce_n = h;
		if (h)
			return;
		if (wp) begin
			repeat (5) begin
				lf = nx(lf);
				wd = {wd[27:0], lf};
			end
			m = em.exists(pa) ? em[pa] : 36'h0;
			for (int g = 0; g < 4; g++)
				if (!ps[g]) m[g*9+:9] = wd[g*9+:9];
			em[pa] = m;
		end
		off = c.select_low_primary_n | ~c.select_high_secondary;
		off = off | c.select_low_tertiary;
		if (!c.load_or_step_strobe) begin
			st = addr;
			k = 2'h0;
			md = off ? 2'h0 : (c.write_n ? 2'h1 : 2'h2);
		end else
			k = k + 2'h1;
		ca = order ? {st[19:2], st[1:0] ^ k} : {st[19:2], st[1:0] + k};
		wp = md == 2'h2 && s != 4'hF;
		pa = ca;
		ps = s;
		if (md == 2'h1)
			eq.push_back(em.exists(ca) ? em[ca] : 36'h0);
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial forever begin
		@(posedge clk);
		if (ce_n)
			chk_data({35'h0, aw}, 36'h0);
		if (rstn && !ce_n && mode === MODE_READ) begin
			#1;
			chk_data(dq, eq.size() > 0 ? eq.pop_front() : ~dq);
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		for (int o = 0; o < 2; o++) begin
			rstn = !o[0];
			order = o[0];
			repeat (2) @(negedge clk);
			rstn = 1'b1;
			addr = 20'h0ABC6 + 20'(o);
			cyc(5'h08, 4'hE, 1'b0);
			cyc(5'h1B, 4'h0, 1'b0);
			cyc(5'h08, 4'h0, 1'b1);
			cyc(5'h1B, 4'hF, 1'b0);
			cyc(5'h1B, 4'h5, 1'b0);
			cyc(5'h09, 4'hF, 1'b0);
			cyc(5'h08, 4'h0, 1'b1);
			repeat (3) cyc(5'h1B, 4'hF, 1'b0);
			cyc(o ? 5'h01 : 5'h0D, 4'h0, 1'b0);
			cyc(5'h12, 4'h0, 1'b0);
			cyc(5'h19, 4'h0, 1'b0);
		end
		give_verdict();
	end
	initial begin
		#2000;
		bad_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
